/* hdl/iss_pkg.sv */
// package of the interrupt source selector: register map, reset values,
// source codes, carrier structs and shared decode functions
// assumes a 32-bit APB register bus and a 16-line processor interrupt input
package iss_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int DATA_W     = 32;
   localparam int SEL_W      = 5;
   localparam int NUM_LINES  = 16;
   localparam int FIRST_SEL  = 4;
   localparam int NUM_SEL    = 12;
   localparam int PER_REG    = 6;
   localparam int NUM_SRC    = 32;

   // ---------------------------------------------------------------
   // register map (byte offsets)
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_SEL_HIGH = 12'h000;
   localparam logic [11:0] OFS_SEL_LOW  = 12'h004;
   localparam logic [11:0] OFS_STATUS   = 12'h008;
   localparam logic [11:0] OFS_MASK     = 12'h00C;

   // ---------------------------------------------------------------
   // reset values and writable bits
   // ---------------------------------------------------------------
   localparam logic [31:0] SEL_LOW_RST  = 32'h250718A4;
   localparam logic [31:0] SEL_HIGH_RST = 32'h08202D43;
   localparam logic [31:0] SEL_VALID    = 32'h7FFF7FFF;
   localparam logic [15:0] LINE_VALID   = 16'hFFF0;
   localparam logic [15:0] MASK_RST     = 16'h0000;

   // ---------------------------------------------------------------
   // selector codes
   // ---------------------------------------------------------------
   localparam logic [4:0] CODE_HOST     = 5'h00;
   localparam logic [4:0] CODE_TIMER0   = 5'h01;
   localparam logic [4:0] CODE_TIMER1   = 5'h02;
   localparam logic [4:0] CODE_SDRAM_A  = 5'h03;
   localparam logic [4:0] CODE_PIN4     = 5'h04;
   localparam logic [4:0] CODE_DMA      = 5'h08;
   localparam logic [4:0] CODE_EMU_XFER = 5'h09;
   localparam logic [4:0] CODE_EMU_RX   = 5'h0A;
   localparam logic [4:0] CODE_EMU_TX   = 5'h0B;
   localparam logic [4:0] CODE_S0_TX    = 5'h0C;
   localparam logic [4:0] CODE_S0_RX    = 5'h0D;
   localparam logic [4:0] CODE_S1_TX    = 5'h0E;
   localparam logic [4:0] CODE_S1_RX    = 5'h0F;
   localparam logic [4:0] CODE_PIN0     = 5'h10;
   localparam logic [4:0] CODE_S2_TX    = 5'h11;
   localparam logic [4:0] CODE_S2_RX    = 5'h12;
   localparam logic [4:0] CODE_TIMER2   = 5'h13;
   localparam logic [4:0] CODE_SDRAM_B  = 5'h14;
   localparam logic [4:0] CODE_CELL     = 5'h17;
   localparam logic [4:0] CODE_CONV     = 5'h1E;
   localparam logic [4:0] CODE_TURBO    = 5'h1F;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic hostIrq;
      logic timer0Irq;
      logic timer1Irq;
      logic timer2Irq;
      logic sdramRefreshTimerAIrq;
      logic sdramRefreshTimerBIrq;
      logic dmaCompletionIrq;
      logic emulationTransferEvent;
      logic emulationExchangeRx;
      logic emulationExchangeTx;
      logic serial0TxIrq;
      logic serial0RxIrq;
      logic serial1TxIrq;
      logic serial1RxIrq;
      logic serial2TxIrq;
      logic serial2RxIrq;
      logic cellInterfaceIrq;
      logic convDecoderIrq;
      logic turboDecoderIrq;
   } iss_src_t;

   typedef struct packed {
      logic       pinEvent0;
      logic [3:0] externalIrqPin;
   } iss_pins_t;

   typedef struct packed {
      logic [31:0] selLow;
      logic [31:0] selHigh;
      logic [15:0] mask;
   } iss_cfg_t;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic [4:0] selField(input logic [31:0] r, input int k);
      logic [31:0] s;
      s = r >> (5 * k + ((k > 2) ? 1 : 0));
      return s[4:0];
   endfunction

   function automatic logic [3:0] firstLine(input logic [15:0] v);
      logic [3:0] t;
      t = 4'h0;
      for (int j = 15; j >= 0; j--) begin
         if (v[j]) begin
            t = 4'(j);
         end
      end
      return t;
   endfunction

endpackage

/* hdl/iss_apb_regs.sv */
// APB slave holding the selector and mask registers; status is held in the selector, read and cleared here
// assumes an APB master on the same clock; zero wait states
`timescale 1ns/1ps
module iss_apb_regs #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                sys_rst,
   // apb
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output      logic [31:0]         prdata,
   output      logic                pready,
   output      logic                pslverr,
   // block side
   input  wire logic [15:0]         status,
   output      iss_pkg::iss_cfg_t   cfg,
   output      logic [15:0]         statusClr
);
   import iss_pkg::*;

   logic [31:0] selLow_q;
   logic [31:0] selHigh_q;
   logic [15:0] mask_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        setup;
   logic        done;
   logic [11:0] ofs;
   logic        hit;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   assign ofs   = 12'(paddr);
   assign hit   = (paddr >> 4) == '0;
   assign setup = psel & ~penable;
   assign done  = psel & penable & pready_q;

   // ---------------------------------------------------------------
   // bus handshake
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~hit;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= 32'h00000000;
         if (hit && !pwrite) begin
            case (ofs)
               OFS_SEL_HIGH: prdata_q <= selHigh_q;
               OFS_SEL_LOW:  prdata_q <= selLow_q;
               OFS_STATUS:   prdata_q <= {16'h0000, status};
               OFS_MASK:     prdata_q <= {16'h0000, mask_q};
               default:      prdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         selLow_q  <= SEL_LOW_RST;
         selHigh_q <= SEL_HIGH_RST;
         mask_q    <= MASK_RST;
      end else if (done && pwrite && hit) begin
         if (ofs == OFS_SEL_LOW) begin
            selLow_q <= pwdata & SEL_VALID;
         end
         if (ofs == OFS_SEL_HIGH) begin
            selHigh_q <= pwdata & SEL_VALID;
         end
         if (ofs == OFS_MASK) begin
            mask_q <= pwdata[15:0] & LINE_VALID;
         end
      end
   end

   assign statusClr = (done && pwrite && hit && ofs == OFS_STATUS) ? (pwdata[15:0] & LINE_VALID) : 16'h0000;
   assign cfg       = '{selLow: selLow_q, selHigh: selHigh_q, mask: mask_q};
   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = pslverr_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_lowWrite;
      psel && penable && pready_q && pwrite && hit && ofs == OFS_SEL_LOW;
   endsequence

   property p_writeLow;
      @(posedge clock) disable iff (sys_rst)
      s_lowWrite |=> selLow_q == ($past(pwdata) & SEL_VALID);
   endproperty
   a_writeLow: assert property (p_writeLow) else $error("low selector write lost");

   property p_unusedZero;
      @(posedge clock) disable iff (sys_rst)
      !selLow_q[15] && !selLow_q[31] && !selHigh_q[15] && !selHigh_q[31];
   endproperty
   a_unusedZero: assert property (p_unusedZero) else $error("unused selector bit set");

   property p_resetSel;
      @(posedge clock)
      $past(sys_rst) |-> selLow_q == SEL_LOW_RST && selHigh_q == SEL_HIGH_RST;
   endproperty
   a_resetSel: assert property (p_resetSel) else $error("selector reset value wrong");

endmodule

/* hdl/iss_selector.sv */
// interrupt source selector: routes 24 event sources onto lines 4..15,
// passes reset and nmi on lines 0 and 1, latches status and raises irq
// assumes all inputs synchronous to clock; registers reached over APB
`timescale 1ns/1ps

// Overview of operation
// - lines 0-3 fixed: reset, nmi, reserved
// - lines 4-15 take source coded in field
// - low register fields at documented bit positions
// - high register uses same field positions
// - lines 4-7 reset to pin events
// - line 8 dma, line 9 emulation transfer
// - lines 10-15 reset to listed sources
// - serial, pin0, timer2, sdram b codes
// - cell and decoder codes; absent when missing
// - pins 4-7 act as external interrupt inputs
// - line 0 highest priority, 15 lowest
module iss_selector #(
   parameter int ADDR_W       = 12,
   parameter bit HAS_CELL     = 1'b1,
   parameter bit HAS_DECODERS = 1'b1
) (
   // clock and reset
   clock,
   sys_rst,
   // apb
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   // event sources
   src,
   pins,
   resetReq,
   nmiReq,
   // processor side
   cpuInt,
   topLine,
   topValid,
   irq
);
   import iss_pkg::*;

   input  wire logic                clock;
   input  wire logic                sys_rst;
   input  wire logic                psel;
   input  wire logic                penable;
   input  wire logic                pwrite;
   input  wire logic [ADDR_W-1:0]   paddr;
   input  wire logic [31:0]         pwdata;
   output      logic [31:0]         prdata;
   output      logic                pready;
   output      logic                pslverr;
   input  wire iss_pkg::iss_src_t   src;
   input  wire iss_pkg::iss_pins_t  pins;
   input  wire logic                resetReq;
   input  wire logic                nmiReq;
   output      logic [15:0]         cpuInt;
   output      logic [3:0]          topLine;
   output      logic                topValid;
   output      logic                irq;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   iss_cfg_t     cfg;
   logic [15:0]  statusClr;
   logic [31:0]  srcVec;
   logic [11:0]  routedD;
   logic [15:0]  cpuInt_q;
   logic [15:0]  status_q;
   logic [15:0]  statusSet;
   logic [3:0]   topLine_q;
   logic         topValid_q;
   logic         irq_q;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   iss_apb_regs #(
      .ADDR_W (ADDR_W)
   ) uRegs (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .status    (status_q),
      .cfg       (cfg),
      .statusClr (statusClr)
   );

   // ---------------------------------------------------------------
   // source table indexed by selector code
   // ---------------------------------------------------------------
   always_comb begin
      srcVec = 32'h00000000;
      srcVec[CODE_HOST]     = src.hostIrq;
      srcVec[CODE_TIMER0]   = src.timer0Irq;
      srcVec[CODE_TIMER1]   = src.timer1Irq;
      srcVec[CODE_SDRAM_A]  = src.sdramRefreshTimerAIrq;
      for (int p = 0; p < 4; p++) begin
         srcVec[CODE_PIN4 + 5'(p)] = pins.externalIrqPin[p];
      end
      srcVec[CODE_DMA]      = src.dmaCompletionIrq;
      srcVec[CODE_EMU_XFER] = src.emulationTransferEvent;
      srcVec[CODE_EMU_RX]   = src.emulationExchangeRx;
      srcVec[CODE_EMU_TX]   = src.emulationExchangeTx;
      srcVec[CODE_S0_TX]    = src.serial0TxIrq;
      srcVec[CODE_S0_RX]    = src.serial0RxIrq;
      srcVec[CODE_S1_TX]    = src.serial1TxIrq;
      srcVec[CODE_S1_RX]    = src.serial1RxIrq;
      srcVec[CODE_PIN0]     = pins.pinEvent0;
      srcVec[CODE_S2_TX]    = src.serial2TxIrq;
      srcVec[CODE_S2_RX]    = src.serial2RxIrq;
      srcVec[CODE_TIMER2]   = src.timer2Irq;
      srcVec[CODE_SDRAM_B]  = src.sdramRefreshTimerBIrq;
      srcVec[CODE_CELL]     = src.cellInterfaceIrq & HAS_CELL;
      srcVec[CODE_CONV]     = src.convDecoderIrq & HAS_DECODERS;
      srcVec[CODE_TURBO]    = src.turboDecoderIrq & HAS_DECODERS;
   end

   // ---------------------------------------------------------------
   // per-line selection
   // ---------------------------------------------------------------
   for (genvar g = 0; g < NUM_SEL; g++) begin : gLine
      logic [4:0] code;
      if (g < PER_REG) begin : gLow
         assign code = selField(cfg.selLow, g);
      end else begin : gHigh
         assign code = selField(cfg.selHigh, g - PER_REG);
      end
      assign routedD[g] = srcVec[code];
   end

   // ---------------------------------------------------------------
   // processor interrupt lines
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cpuInt_q <= 16'h0000;
      end else begin
         cpuInt_q <= {routedD, 2'b00, nmiReq, resetReq};
      end
   end

   // ---------------------------------------------------------------
   // priority of pending lines
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         topLine_q  <= 4'h0;
         topValid_q <= 1'b0;
      end else begin
         topLine_q  <= firstLine(cpuInt_q);
         topValid_q <= |cpuInt_q;
      end
   end

   // ---------------------------------------------------------------
   // sticky status, write one to clear, set wins
   // ---------------------------------------------------------------
   assign statusSet = {cpuInt_q[15:4], 4'h0};

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         status_q <= 16'h0000;
      end else begin
         status_q <= (status_q & ~statusClr) | statusSet;
      end
   end

   // ---------------------------------------------------------------
   // interrupt output
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & cfg.mask);
      end
   end

   assign cpuInt   = cpuInt_q;
   assign topLine  = topLine_q;
   assign topValid = topValid_q;
   assign irq      = irq_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_fixedLines;
      @(posedge clock) disable iff (sys_rst)
      ##1 cpuInt_q[3:2] == 2'b00 && cpuInt_q[0] == $past(resetReq) && cpuInt_q[1] == $past(nmiReq);
   endproperty
   a_fixedLines: assert property (p_fixedLines) else $error("fixed line mismatch");

   property p_route4;
      @(posedge clock) disable iff (sys_rst)
      1'b1 |=> cpuInt_q[4] == $past(srcVec[cfg.selLow[4:0]]);
   endproperty
   a_route4: assert property (p_route4) else $error("line 4 routing wrong");

   property p_route15;
      @(posedge clock) disable iff (sys_rst)
      1'b1 |=> cpuInt_q[15] == $past(srcVec[cfg.selHigh[30:26]]);
   endproperty
   a_route15: assert property (p_route15) else $error("line 15 routing wrong");

   property p_route7;
      @(posedge clock) disable iff (sys_rst)
      cfg.selLow[20:16] == CODE_PIN4 |=> cpuInt_q[7] == $past(pins.externalIrqPin[0]);
   endproperty
   a_route7: assert property (p_route7) else $error("line 7 field position wrong");

   property p_serial;
      @(posedge clock) disable iff (sys_rst)
      cfg.selHigh[9:5] == CODE_S0_TX |=> cpuInt_q[11] == $past(src.serial0TxIrq);
   endproperty
   a_serial: assert property (p_serial) else $error("serial code routing wrong");

   property p_absent;
      @(posedge clock) disable iff (sys_rst)
      cfg.selLow[4:0] == CODE_CELL |=> cpuInt_q[4] == ($past(src.cellInterfaceIrq) && HAS_CELL);
   endproperty
   a_absent: assert property (p_absent) else $error("absent source seen");

   property p_priority;
      @(posedge clock) disable iff (sys_rst)
      ##1 topValid_q |-> (($past(cpuInt_q) >> topLine_q) & 16'h0001) == 16'h0001
                         && ($past(cpuInt_q) & ((16'h0001 << topLine_q) - 16'h0001)) == 16'h0000;
   endproperty
   a_priority: assert property (p_priority) else $error("priority not lowest line");

   sequence s_eventSeen;
      cpuInt_q[6] && cfg.mask[6] ##1 cfg.mask[6];
   endsequence

   sequence s_heldThenIrq;
      status_q[6] ##1 irq_q;
   endsequence

   property p_stickyIrq;
      @(posedge clock) disable iff (sys_rst)
      s_eventSeen |-> s_heldThenIrq;
   endproperty
   a_stickyIrq: assert property (p_stickyIrq) else $error("status or irq missed");

   property p_irqOff;
      @(posedge clock) disable iff (sys_rst)
      (status_q & cfg.mask) == 16'h0000 |=> !irq_q;
   endproperty
   a_irqOff: assert property (p_irqOff) else $error("irq without masked status");

endmodule

/* bench/iss_source_model.sv */
// peripheral event model: one level per selector code feeds the source bundle
// assumes a code-indexed event vector from the bench; reserved codes drive nothing
`timescale 1ns/1ps
module iss_source_model (
   // events indexed by selector code
   input  wire logic [31:0]        ev,
   // towards the selector
   output      iss_pkg::iss_src_t  src,
   output      iss_pkg::iss_pins_t pins
);
   import iss_pkg::*;
   // ---------------------------------------------------------------
   // on-chip sources
   // ---------------------------------------------------------------
   assign src = '{ev[0], ev[1], ev[2], ev[19], ev[3], ev[20], ev[8], ev[9], ev[10], ev[11],
                  ev[12], ev[13], ev[14], ev[15], ev[17], ev[18], ev[23], ev[30], ev[31]};
   // ---------------------------------------------------------------
   // pin events, external pins as inputs
   // ---------------------------------------------------------------
   assign pins = '{ev[16], ev[7:4]};
endmodule

/* bench/interrupt_source_selector_tb.sv */
// self-checking bench for the interrupt source selector
// assumes the selector top, the event model and an APB master task
`timescale 1ns/1ps
module interrupt_source_selector_tb;
   import iss_pkg::*;
   localparam logic [31:0] VALID_CODES = 32'hC09FFFFF;
   localparam int          LIMIT       = 20000;
   logic        clock     = 1'b0;
   logic        sys_rst   = 1'b1;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [11:0] paddr     = 12'h000;
   logic [31:0] pwdata    = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] ev        = 32'h00000000;
   iss_src_t    src;
   iss_pins_t   pins;
   logic        resetReq  = 1'b0;
   logic        nmiReq    = 1'b0;
   logic [15:0] cpuInt;
   logic [3:0]  topLine;
   logic        topValid;
   logic        irq;
   logic [31:0] rdData;
   logic        rdErr;
   int          miscompares = 0;
   int          n_compared  = 0;
   int          cycles      = 0;
   int          defCode [12] = '{4, 5, 6, 7, 8, 9, 3, 10, 11, 0, 1, 2};

   always #5 clock = ~clock;

   iss_source_model iss_source_model_inst (
      .ev   (ev),
      .src  (src),
      .pins (pins)
   );

   iss_selector iss_selector_inst (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .src      (src),
      .pins     (pins),
      .resetReq (resetReq),
      .nmiReq   (nmiReq),
      .cpuInt   (cpuInt),
      .topLine  (topLine),
      .topValid (topValid),
      .irq      (irq)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] fld(input logic [4:0] c);
      return {1'b0, c, c, c, 1'b0, c, c, c};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // one APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         print_verdict();
      end
   end

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      tick(8);
      sys_rst <= 1'b0;
      // reset values of both selector registers, status and mask
      apb(1'b0, OFS_SEL_LOW, 32'h0);
      chk(rdData, {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04});
      chk(32'(rdErr), 32'h0);
      apb(1'b0, OFS_SEL_HIGH, 32'h0);
      chk(rdData, {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0B, 5'h0A, 5'h03});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rdData, 32'h0);
      apb(1'b0, OFS_MASK, 32'h0);
      chk(rdData, 32'h0);
      // default routing: each line sees only its own source
      for (int l = 0; l < 12; l++) begin
         ev <= 32'h1 << defCode[l];
         tick(2);
         chk(32'(cpuInt), 32'h1 << (l + 4));
      end
      // fixed lines and priority
      ev <= 32'h0;
      resetReq <= 1'b1;
      nmiReq <= 1'b1;
      tick(3);
      chk(32'(cpuInt), 32'h3);
      chk({27'h0, topValid, topLine}, 32'h10);
      resetReq <= 1'b0;
      nmiReq <= 1'b0;
      ev <= 32'h42;
      tick(3);
      chk({27'h0, topValid, topLine}, 32'h16);
      // status, mask and interrupt output
      ev <= 32'h0;
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rdData, 32'h0000FFF0);
      apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
      apb(1'b1, OFS_MASK, 32'h00000040);
      tick(3);
      chk(32'(irq), 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rdData, 32'h0);
      ev <= 32'h40;
      tick(4);
      chk(32'(irq), 32'h1);
      apb(1'b1, OFS_MASK, 32'h0);
      tick(3);
      chk(32'(irq), 32'h0);
      // every valid code on every line, reserved codes skipped
      for (int c = 0; c < 32; c++) begin
         if (VALID_CODES[c]) begin
            apb(1'b1, OFS_SEL_LOW, fld(5'(c)));
            apb(1'b1, OFS_SEL_HIGH, fld(5'(c)));
            ev <= 32'h1 << c;
            tick(2);
            chk(32'(cpuInt), VALID_CODES[c] ? 32'hFFF0 : 32'h0);
            ev <= ~(32'h1 << c);
            tick(2);
            chk(32'(cpuInt), 32'h0);
         end
      end
      // readback drops bits 15 and 31; change lands on the next clock
      apb(1'b1, OFS_SEL_LOW, 32'hFFFFFFFF);
      apb(1'b0, OFS_SEL_LOW, 32'h0);
      chk(rdData, 32'h7FFF7FFF);
      ev <= 32'h20;
      apb(1'b1, OFS_SEL_LOW, 32'h7FFF7FE5);
      tick(1);
      chk(32'(cpuInt[4]), 32'h0);
      tick(1);
      chk(32'(cpuInt), 32'h0010);
      // unmapped address refused
      apb(1'b1, 12'h010, 32'h0);
      chk(32'(rdErr), 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk({rdData[30:0], rdErr}, 32'h1);
      apb(1'b0, OFS_SEL_LOW, 32'h0);
      chk(rdData, 32'h7FFF7FE5);
      print_verdict();
   end
endmodule
